// ### core/ppmux_params.svh
// Operation
// - reset puts the interrupt multiplexer in non-compatible (mux) mode
// - after reset the printer lines stay idle until software sets run; the interrupt pin ignores run
// - strobe output tells the printer to latch the data byte
// - autofeed output asks the printer to advance form paper
// - initialize output starts the printer's init routine
// - select output selects the attached printer
// - outside stand-alone mode the interrupt pin feeds the mux
// - in stand-alone mode the pin drives the port interrupt
// - port interrupt pin stays tri-stated unless control bit 4 is set
// - alternate mode: set on ack rise, cleared by status read end
// - sixteen inputs time-shared onto two outputs by select code
// - rom width flag travels on mux output b
// - keyboard interrupt travels on mux output b
// - address bit 20 gate travels on mux output b
// - mux outputs come from mux logic, serial irqs in stand-alone
`ifndef PPMUX_PARAMS_SVH
`define PPMUX_PARAMS_SVH
`define PP_OFS_DATA    8'h00
`define PP_OFS_CTRL    8'h04
`define PP_OFS_STATUS  8'h08
`define PP_OFS_MODE    8'h0C
`define PP_DATA_RST    8'h00
`define PP_CTRL_RST    6'h00
`define PP_MODE_RST    3'h0
`define PP_IRQ_EN_BIT  4
`define PP_STAT_ACK    4
`define PP_MUX_MAP     64'hFEDCBA9876543210
`define AXI_OKAY       2'h0
`define AXI_SLVERR     2'h2
`endif

// ### core/ppmux_pkg.sv
`default_nettype none
package ppmux_pkg;
  typedef struct packed {
    logic dir_in;
    logic irq_en;
    logic select_out;
    logic init;
    logic autofeed;
    logic strobe;
  } ctrl_t;
  typedef struct packed {
    logic run;
    logic alt_compat;
    logic standalone;
  } mode_t;
  typedef struct packed {
    logic ack;
    logic paper_out;
    logic busy;
    logic selected;
    logic error;
  } pstat_t;
endpackage
`default_nettype wire

// ### core/printer_port_irq_multiplexer.sv
// The AXI4-Lite slave port and the register offsets were decided locally.
`include "ppmux_params.svh"
`default_nettype none
module printer_port_irq_multiplexer
  import ppmux_pkg::*;
#(
  parameter int          ADDR_W  = 8,
  parameter logic [63:0] MUX_MAP = `PP_MUX_MAP
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_reset_n,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  input  wire logic [7:0]        i_printer_data_bus,
  output logic [7:0]             o_printer_data_bus,
  output logic                   o_printer_data_oe,
  output logic                   o_printer_latch_pulse,
  output logic                   o_paper_autofeed,
  output logic                   o_printer_init,
  output logic                   o_printer_select_out,
  input  wire logic              i_printer_error,
  input  wire logic              i_printer_selected_in,
  input  wire logic              i_printer_busy,
  input  wire logic              i_paper_out_in,
  input  wire logic              i_printer_ack,
  input  wire logic              i_printer_interrupt,
  output logic                   o_printer_interrupt,
  output logic                   o_printer_interrupt_oe,
  input  wire logic [2:0]        i_mux_select_code,
  input  wire logic [10:0]       i_irq_lines,
  input  wire logic              i_cpu_reset_request,
  input  wire logic              i_rom_width_flag,
  input  wire logic              i_keyboard_interrupt,
  input  wire logic              i_address_bit20_gate,
  input  wire logic              i_serial0_irq,
  input  wire logic              i_serial1_irq,
  output logic                   o_mux_output_a,
  output logic                   o_mux_output_b
);

  if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 4 and 32");
  end

  // ***************************************
  // mux table lookup
  // ***************************************
  function automatic logic [3:0] map_sel(input logic [2:0] code,
                                         input logic       side);
    return MUX_MAP[{side, code, 2'b00} +: 4];
  endfunction

  // ***************************************
  // state
  // ***************************************
  logic [7:0]        data_q;
  ctrl_t             ctrl_q;
  mode_t             mode_q;
  pstat_t            stat_s1_q;
  pstat_t            stat_s2_q;
  logic              ack_prev_q;
  logic              irq_q;
  logic              irq_d;
  logic              mux_a_q;
  logic              mux_b_q;
  logic              aw_hold_q;
  logic              w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0]        wdata_q;
  logic              wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              rd_stat_q;

  // ***************************************
  // register bus decode
  // ***************************************
  wire               aw_take  = i_awvalid & o_awready;
  wire               w_take   = i_wvalid & o_wready;
  wire               aw_have  = aw_hold_q | aw_take;
  wire               w_have   = w_hold_q | w_take;
  wire               do_write = aw_have & w_have & ~bvalid_q;
  wire [ADDR_W-1:0]  wr_addr  = aw_hold_q ? awaddr_q : i_awaddr;
  wire [7:0]         wr_byte  = w_hold_q ? wdata_q : i_wdata[7:0];
  wire               wr_lane  = w_hold_q ? wstrb_q : i_wstrb[0];
  wire               wr_data  = wr_addr == ADDR_W'(`PP_OFS_DATA);
  wire               wr_ctrl  = wr_addr == ADDR_W'(`PP_OFS_CTRL);
  wire               wr_mode  = wr_addr == ADDR_W'(`PP_OFS_MODE);
  wire               wr_stat  = wr_addr == ADDR_W'(`PP_OFS_STATUS);
  wire               wr_hit   = wr_data | wr_ctrl | wr_mode | wr_stat;
  wire               wr_en    = do_write & wr_lane;
  wire               ar_take  = i_arvalid & o_arready;
  wire               rd_stat  = i_araddr == ADDR_W'(`PP_OFS_STATUS);
  wire               rd_done  = rvalid_q & i_rready & rd_stat_q;

  assign o_awready = ~aw_hold_q & ~bvalid_q;
  assign o_wready  = ~w_hold_q & ~bvalid_q;
  assign o_arready = ~rvalid_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_rvalid  = rvalid_q;
  assign o_rdata   = rdata_q;
  assign o_rresp   = rresp_q;

  // in input direction the data register reads back the pins
  wire [7:0]  data_rd = ctrl_q.dir_in ? i_printer_data_bus : data_q;
  wire [31:0] rd_word =
      (i_araddr == ADDR_W'(`PP_OFS_DATA))  ? {24'h000000, data_rd} :
      (i_araddr == ADDR_W'(`PP_OFS_CTRL))  ? {26'h0, ctrl_q} :
      rd_stat                               ? {26'h0, irq_q,
                                               stat_s2_q} :
      (i_araddr == ADDR_W'(`PP_OFS_MODE))  ? {29'h0, mode_q} :
                                              32'h00000000;
  wire        rd_hit  = rd_stat |
                        (i_araddr == ADDR_W'(`PP_OFS_DATA)) |
                        (i_araddr == ADDR_W'(`PP_OFS_CTRL)) |
                        (i_araddr == ADDR_W'(`PP_OFS_MODE));

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 8'h00;
      wstrb_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `AXI_OKAY;
    end else begin
      if (aw_take && !do_write) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= i_awaddr;
      end
      if (w_take && !do_write) begin
        w_hold_q <= 1'b1;
        wdata_q  <= i_wdata[7:0];
        wstrb_q  <= i_wstrb[0];
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
      end else if (i_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `AXI_OKAY;
      rd_stat_q <= 1'b0;
    end else if (ar_take) begin
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= rd_hit ? `AXI_OKAY : `AXI_SLVERR;
      rd_stat_q <= rd_stat;
    end else if (i_rready) begin
      rvalid_q  <= 1'b0;
      rd_stat_q <= 1'b0;
    end
  end

  // ***************************************
  // software registers
  // ***************************************
  // status is read-only; a write to it is accepted and dropped
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      data_q <= `PP_DATA_RST;
      ctrl_q <= `PP_CTRL_RST;
      mode_q <= `PP_MODE_RST;
    end else if (wr_en) begin
      if (wr_data)
        data_q <= wr_byte;
      if (wr_ctrl)
        ctrl_q <= ctrl_t'(wr_byte[5:0]);
      if (wr_mode)
        mode_q <= mode_t'(wr_byte[2:0]);
    end
  end

  // ***************************************
  // printer lines
  // ***************************************
  // nothing reaches the printer until software sets run
  assign o_printer_latch_pulse = ctrl_q.strobe & mode_q.run;
  assign o_paper_autofeed      = ctrl_q.autofeed & mode_q.run;
  assign o_printer_init        = ctrl_q.init & mode_q.run;
  assign o_printer_select_out  = ctrl_q.select_out & mode_q.run;
  assign o_printer_data_bus    = data_q;
  assign o_printer_data_oe     = mode_q.run & ~ctrl_q.dir_in;

  // ***************************************
  // status sync and printer interrupt
  // ***************************************
  wire pstat_t stat_raw = '{ack: i_printer_ack, paper_out: i_paper_out_in,
                            busy: i_printer_busy,
                            selected: i_printer_selected_in,
                            error: i_printer_error};
  wire ack_rise = stat_s2_q.ack & ~ack_prev_q;
  wire ack_fall = ~stat_s2_q.ack & ack_prev_q;

  // a rise in the same cycle as a clearing read keeps the flag set
  always_comb begin
    irq_d = irq_q;
    if (ack_rise)
      irq_d = 1'b1;
    else if (mode_q.alt_compat && rd_done)
      irq_d = 1'b0;
    else if (!mode_q.alt_compat && ack_fall)
      irq_d = 1'b0;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      stat_s1_q  <= '0;
      stat_s2_q  <= '0;
      ack_prev_q <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      stat_s1_q  <= stat_raw;
      stat_s2_q  <= stat_s1_q;
      ack_prev_q <= stat_s2_q.ack;
      irq_q      <= irq_d;
    end
  end

  assign o_printer_interrupt    = irq_q & mode_q.standalone;
  assign o_printer_interrupt_oe = mode_q.standalone &
                                  ctrl_q.irq_en;

  // ***************************************
  // interrupt multiplexer
  // ***************************************
  wire        pin_irq_in = ~mode_q.standalone & i_printer_interrupt;
  wire [15:0] mux_in     = {i_address_bit20_gate,
                            i_keyboard_interrupt,
                            i_rom_width_flag,
                            i_cpu_reset_request,
                            pin_irq_in,
                            i_irq_lines};
  wire [3:0]  sel_a      = map_sel(i_mux_select_code, 1'b0);
  wire [3:0]  sel_b      = map_sel(i_mux_select_code, 1'b1);

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      mux_a_q <= 1'b0;
      mux_b_q <= 1'b0;
    end else begin
      mux_a_q <= mode_q.standalone ? i_serial0_irq : mux_in[sel_a];
      mux_b_q <= mode_q.standalone ? i_serial1_irq : mux_in[sel_b];
    end
  end

  assign o_mux_output_a = mux_a_q;
  assign o_mux_output_b = mux_b_q;

  // ***************************************
  // checks
  // ***************************************
  sequence ack_rises;
    !stat_s2_q.ack ##1 stat_s2_q.ack;
  endsequence

  sequence ack_falls;
    stat_s2_q.ack ##1 !stat_s2_q.ack;
  endsequence

  chk_reset_mode: assert property (@(posedge i_core_clk)
    $past(!i_reset_n) |-> !mode_q.standalone && !mode_q.run)
    else $error("mode not cleared by reset");

  chk_idle_lines: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) !mode_q.run |-> !o_printer_data_oe &&
    !o_printer_latch_pulse && !o_paper_autofeed && !o_printer_init &&
    !o_printer_select_out)
    else $error("printer lines active while idle");

  chk_irq_set: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) ack_rises |=> irq_q)
    else $error("ack rise did not set interrupt");

  chk_classic_clear: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) !mode_q.alt_compat throughout ack_falls
    |=> !irq_q)
    else $error("ack fall did not clear interrupt");

  chk_alt_clear: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n)
    mode_q.alt_compat && rd_done && !ack_rise |=> !irq_q)
    else $error("status read did not clear interrupt");

  chk_alt_hold: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n)
    mode_q.alt_compat && irq_q && !rd_done |=> irq_q)
    else $error("alternate interrupt dropped early");

  chk_pin_tristate: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n)
    $rose(o_printer_interrupt_oe) |-> $past(wr_en && (wr_ctrl || wr_mode)))
    else $error("interrupt pin driven while disabled");

  chk_sync_delay: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) $past(!i_reset_n, 2) ||
    stat_s2_q.ack == $past(i_printer_ack, 2))
    else $error("ack sync not two stages");

  chk_mux_pair: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) !mode_q.standalone && $stable(mode_q)
    |=> o_mux_output_a == $past(mux_in[sel_a]) &&
        o_mux_output_b == $past(mux_in[sel_b]))
    else $error("mux output does not follow table");

  chk_serial_pass: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) mode_q.standalone && $stable(mode_q)
    |=> o_mux_output_a == $past(i_serial0_irq) &&
        o_mux_output_b == $past(i_serial1_irq))
    else $error("stand-alone outputs not serial irqs");

endmodule
`default_nettype wire

// ### tb/printer_model.sv
`default_nettype none
module printer_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_latch,
  input  wire logic       i_select,
  input  wire logic       i_paper_empty,
  input  wire logic [3:0] i_delay,
  output logic            o_error,
  output logic            o_selected,
  output logic            o_busy,
  output logic            o_paper_out,
  output logic            o_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************
  // one print cycle: busy, then ack pulse
  // ************************************
  logic [5:0] cnt_q;
  wire  [5:0] busy_end = {2'h0, i_delay} + 6'h02;
  wire  [5:0] ack_end  = busy_end + 6'h08;
  // a held strobe does not retrigger; the line must drop first
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) cnt_q <= 6'h00;
    else if (cnt_q == 6'h00) cnt_q <= {5'h00, i_latch};
    else if (cnt_q != ack_end) cnt_q <= cnt_q + 6'h01;
    else if (!i_latch) cnt_q <= 6'h00;
  end
  assign o_selected  = i_select;
  assign o_paper_out = i_paper_empty;
  assign o_error     = i_paper_empty | ~i_select;
  assign o_busy      = (cnt_q != 6'h00) && (cnt_q <= busy_end);
  assign o_ack       = (cnt_q > busy_end) && (cnt_q < ack_end);
endmodule
`default_nettype wire

// ### tb/tb_printer_port_irq_multiplexer.sv
`include "ppmux_params.svh"
`default_nettype none
module tb_printer_port_irq_multiplexer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, pd_out, pd_host;
  logic [31:0] wdata, rdata;
  logic        awready, wready, bvalid, arready, rvalid, pd_oe;
  logic [1:0]  bresp, rresp;
  logic        stb, afd, init, slo, err, sli, busy, pout, ack;
  logic        irq_out, irq_oe, s0, s1, mux_a, mux_b, paper_empty;
  logic [2:0]  code;
  logic [15:0] mux_in;
  logic [3:0]  delay;
  logic [31:0] d;
  int          failures, checks_done;
  wire  [7:0]  pd_in = pd_oe ? pd_out : pd_host;
  wire         irq_pin = irq_oe ? irq_out : mux_in[11];
  wire  [3:0]  lines = {slo, init, afd, stb};

  printer_port_irq_multiplexer DUT (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_printer_data_bus(pd_in),
    .o_printer_data_bus(pd_out), .o_printer_data_oe(pd_oe),
    .o_printer_latch_pulse(stb), .o_paper_autofeed(afd),
    .o_printer_init(init), .o_printer_select_out(slo),
    .i_printer_error(err), .i_printer_selected_in(sli),
    .i_printer_busy(busy), .i_paper_out_in(pout), .i_printer_ack(ack),
    .i_printer_interrupt(irq_pin), .o_printer_interrupt(irq_out),
    .o_printer_interrupt_oe(irq_oe), .i_mux_select_code(code),
    .i_irq_lines(mux_in[10:0]), .i_cpu_reset_request(mux_in[12]),
    .i_rom_width_flag(mux_in[13]), .i_keyboard_interrupt(mux_in[14]),
    .i_address_bit20_gate(mux_in[15]), .i_serial0_irq(s0),
    .i_serial1_irq(s1), .o_mux_output_a(mux_a), .o_mux_output_b(mux_b));

  printer_model prn (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_latch(stb), .i_select(slo),
    .i_paper_empty(paper_empty), .i_delay(delay), .o_error(err),
    .o_selected(sli), .o_busy(busy), .o_paper_out(pout), .o_ack(ack));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ************************************
  // shared helpers
  // ************************************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // handshakes are judged at negedge, released after the next posedge
  // no cycle limit in the bus tasks: only the watchdog ends a wait
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er = `AXI_OKAY);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      if (tb) chk("bresp", bresp, er);
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end while (!tb);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er = `AXI_OKAY);
    logic ta, tr;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      if (tr) d = rdata;
      if (tr) chk("rresp", rresp, er);
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end while (!tr);
  endtask
  task automatic wait_ack(input logic lvl);
    while (ack !== lvl) @(negedge clk);
  endtask

  // ************************************
  // scenarios
  // ************************************
  task automatic t_reset;
    chk("lines", {lines, pd_oe, irq_oe, mux_a, mux_b}, 0);
    rd(`PP_OFS_MODE);
    chk("mode", d, 0);
    rd(`PP_OFS_CTRL);
    chk("ctrl", d, 0);
    rd(8'h10, `AXI_SLVERR);
    wr(8'h10, 32'h0000_00FF, `AXI_SLVERR);
    $display("test reset done");
  endtask
  task automatic t_lines;
    wr(`PP_OFS_CTRL, 32'h0000_000F);
    cyc(1);
    chk("idle lines", {lines, pd_oe}, 0);
    wr(`PP_OFS_MODE, 32'h0000_0004);
    for (int i = 0; i < 4; i++) begin
      wr(`PP_OFS_CTRL, 32'h1 << i);
      cyc(1);
      chk("line", lines, 4'h1 << i);
    end
    wr(`PP_OFS_DATA, 32'h0000_00A5);
    cyc(1);
    chk("data out", {pd_oe, pd_out}, 9'h1A5);
    @(posedge clk);
    pd_host <= 8'h3C;
    wr(`PP_OFS_CTRL, 32'h0000_0020);
    rd(`PP_OFS_DATA);
    chk("data in", {pd_oe, d[7:0]}, 9'h03C);
    $display("test lines done");
  endtask
  task automatic t_status;
    wr(`PP_OFS_CTRL, 32'h0000_0008);
    cyc(4);
    rd(`PP_OFS_STATUS);
    chk("status sel", d[3:0], 4'h2);
    paper_empty <= 1'b1;
    cyc(4);
    rd(`PP_OFS_STATUS);
    chk("status pe", d[3:0], 4'hB);
    wr(`PP_OFS_CTRL, 32'h0000_0000);
    paper_empty <= 1'b0;
    cyc(4);
    rd(`PP_OFS_STATUS);
    chk("status desel", d[3:0], 4'h1);
    $display("test status done");
  endtask
  task automatic t_irq(input logic alt);
    cyc(40);
    wr(`PP_OFS_MODE, {29'h0, 1'b1, alt, 1'b1});
    wr(`PP_OFS_CTRL, {27'h0, !alt, 4'h9});
    cyc(4);
    rd(`PP_OFS_STATUS);
    chk("busy", d[2], 1'b1);
    wait_ack(1'b1);
    chk("early irq", irq_out, 1'b0);
    cyc(4);
    chk("irq set", {irq_out, irq_oe}, {1'b1, !alt});
    wait_ack(1'b0);
    cyc(4);
    chk("irq ack fall", irq_out, alt);
    wr(`PP_OFS_CTRL, 32'h0000_0018);
    chk("irq oe", irq_oe, 1'b1);
    rd(`PP_OFS_STATUS);
    chk("status flag", d[5], alt);
    cyc(1);
    chk("irq after read", irq_out, 1'b0);
    wr(`PP_OFS_MODE, 32'h0000_0004);
    $display("test interrupt done");
  endtask
  task automatic t_mux;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      code   <= k[2:0];
      mux_in <= k[3] ? ~(16'h0101 << k[2:0]) : (16'h0101 << k[2:0]);
      cyc(2);
      chk("mux a", {irq_oe, mux_a}, {1'b0, !k[3]});
      chk("mux b", mux_b, !k[3]);
    end
    wr(`PP_OFS_MODE, 32'h0000_0005);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      {s1, s0} <= s[1:0];
      mux_in   <= {8{~s[1:0]}};
      cyc(2);
      chk("serial", {mux_b, mux_a}, s[1:0]);
    end
    $display("test mux done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, pd_host, wdata, code} = 59'h0;
    {mux_in, s0, s1, paper_empty, delay} = 23'h0;
    failures = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    t_reset();
    t_lines();
    t_status();
    // a long busy phase so the status read still sees busy in both modes
    delay <= 4'hF;
    t_irq(1'b0);
    t_irq(1'b1);
    t_mux();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
